// ==== verilog/freq_ref_cfg.svh ====
`ifndef FREQ_REF_CFG_SVH
`define FREQ_REF_CFG_SVH
// ***********************************
// register byte offsets
// ***********************************
`define OFS_SRC_CTRL   8'h00
`define OFS_BINDING    8'h04
`define OFS_MAX_FREQ   8'h08
`define OFS_CURVE_SEL  8'h0c
`define OFS_PULSE_LINE 8'h10
`define OFS_UPDOWN     8'h14
`define OFS_COMM_FREQ  8'h18
`define OFS_LEN_SET    8'h1c
`define OFS_PULSE_PM   8'h20
`define OFS_ACT_LEN    8'h24
`define OFS_CNT_SET    8'h28
`define OFS_CNT_DESIG  8'h2c
`define OFS_CNT_VALUE  8'h30
`define OFS_STATUS     8'h34
`define OFS_DI_FUNC    8'h38
`define OFS_DO_FUNC    8'h3c
`define OFS_MULTI_BASE 8'h80
`define OFS_CURVE_BASE 8'hc0
// ***********************************
// source control and curve select fields
// ***********************************
`define F_MAIN_LSB     0
`define F_AUX_LSB      4
`define F_COMB_LSB     8
`define F_OP_LSB       12
`define F_CMD_LSB      14
`define F_INVERT       16
`define F_REV_INHIBIT  17
`define F_PID_AUTO     18
`define F_CURVE2_LSB   4
// ***********************************
// reset values
// ***********************************
`define SRC_CTRL_RST   32'h0000_0000
`define MAX_FREQ_RST   16'h1388
`define PULSE_LINE_RST 32'h6464_0000
`define PPM_RST        16'h0001
`define DO_FUNC_RST    12'h248
// ***********************************
// scaling and timing
// ***********************************
`define FULL_SCALE     1000
`define PULSE_FULL_HZ  100000
`define PULSE_GATE_NS  10000000
`define CLK_PERIOD_NS  10
// ***********************************
// input and output function codes
// ***********************************
`define DI_FN_UP       6'd6
`define DI_FN_DOWN     6'd7
`define DI_FN_MULTI0   6'd12
`define DI_FN_SWITCH   6'd18
`define DI_FN_COUNT    6'd25
`define DI_FN_LEN      6'd27
`define DI_FN_LEN_RST  6'd28
`define DI_FN_PID_SET  6'd43
`define DO_FN_CNT_SET  6'd8
`define DO_FN_CNT_DES  6'd9
`define DO_FN_LEN      6'd10
`endif

// ==== verilog/freq_ref_pkg.sv ====
package freq_ref_pkg;
	typedef logic signed [16:0] setting_t;
	typedef enum logic [3:0] {
		SRC_UPDOWN     = 4'h0,
		SRC_UPDOWN_RET = 4'h1,
		SRC_AIN_ONE    = 4'h2,
		SRC_AIN_TWO    = 4'h3,
		SRC_NONE       = 4'h4,
		SRC_PULSE      = 4'h5,
		SRC_MULTI      = 4'h6,
		SRC_PROGRAM    = 4'h7,
		SRC_PID        = 4'h8,
		SRC_COMM       = 4'h9
	} source_t;
	typedef enum logic [2:0] {
		CMB_MAIN     = 3'h0,
		CMB_AUX      = 3'h1,
		CMB_ARITH    = 3'h2,
		CMB_SW_MA    = 3'h3,
		CMB_SW_MR    = 3'h4,
		CMB_SW_AR    = 3'h5
	} combine_t;
	typedef enum logic [1:0] {
		OP_ADD = 2'h0,
		OP_SUB = 2'h1,
		OP_MAX = 2'h2,
		OP_MIN = 2'h3
	} arith_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} bus_state_t;
endpackage

// ==== verilog/param_mem.sv ====
module param_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock
	input  wire logic                     core_clk,
	// write port
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	// read port
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data
);
	logic [WIDTH-1:0] mem_r [DEPTH];

	initial begin
		if (WIDTH < 1 || DEPTH < 2)
			$error("param_mem: bad geometry");
	end

	// table contents are software state, so no reset
	always_ff @(posedge core_clk) begin
		if (wr_en)
			mem_r[wr_addr] <= wr_data;
		rd_data <= mem_r[rd_addr];
	end
endmodule // param_mem

// ==== verilog/freq_ref_core.sv ====
// Operation
// [RQ1] two independent channels, main and auxiliary, each can set the target
// [RQ2] both selectors offer up/down, retained up/down, analog, pulse, multi, program, comm
// [RQ3] combine selector picks main, aux, arithmetic result, or input-driven switchover
// [RQ4] arithmetic combination is sum, difference, larger or smaller of the two
// [RQ5] command source bound to a channel overrides both main and aux
// [RQ6] analog full scale maps to the maximum frequency
// [RQ7] five selectable analog curves held in a configuration table
// [RQ8] pulse reference only on the fast input, two-point line up to 100 kHz
// [RQ9] configurer selects the process-controller code for closed-loop control
// [RQ10] two controller parameter sets, switched automatically or by an input
// [RQ11] multi-reference code picks one of sixteen stored frequencies via functions 12-15
// [RQ12] index formed from assigned inputs, missing bits zero, times maximum frequency
// [RQ13] direction invert set to one reverses rotation of a run command
// [RQ14] comm source with reverse allowed runs reverse on negative set frequency
// [RQ15] reverse inhibited plus reverse request gives zero frequency, no output
// [RQ16] length equals pulses over pulses per meter; output when above set length
// [RQ17] length reset input clears the accumulated length
// [RQ18] length counts pulses only, direction ignored, fast input only
// [RQ19] counter stops at set count and drives the set-count output
// [RQ20] designated count drives its output while counting continues
// [RQ21] configurer keeps designated count within set count, outputs distinct
// [RQ22] event count value survives power failure; here cnt_r clears on reset and software reads and restores it
// [RQ23] reached outputs update in the same cycle as the counter; the hit flags do, do_out follows one cycle later
`include "freq_ref_cfg.svh"
module freq_ref_core
	import freq_ref_pkg::*;
#(
	parameter int GATE_CYCLES = `PULSE_GATE_NS / `CLK_PERIOD_NS,
	parameter int NUM_DI      = 5,
	parameter int NUM_DO      = 2
) (
	// clock and reset
	input  wire logic               core_clk,
	input  wire logic               arst_n,
	// avalon-mm slave
	input  wire logic [7:0]         address,
	input  wire logic               read,
	input  wire logic               write,
	input  wire logic [31:0]        writedata,
	input  wire logic [3:0]         byteenable,
	output logic      [31:0]        readdata,
	output logic                    waitrequest,
	// terminals and analog values, 0.1 % units
	input  wire logic [NUM_DI-1:0]  di_in,
	input  wire logic [9:0]         analog_input_one,
	input  wire logic [9:0]         analog_input_two,
	// command and controller side
	input  wire logic               run_cmd,
	input  wire logic               rev_cmd,
	input  wire logic signed [15:0] pid_setting,
	input  wire logic signed [15:0] program_setting,
	input  wire logic               pid_dev_large,
	// to the motor control core
	output logic      [15:0]        target_freq,
	output logic                    run_reverse,
	output logic                    drive_enable,
	output logic                    pid_set_sel,
	output logic      [NUM_DO-1:0]  do_out
);
	localparam int FAST = NUM_DI - 1;
	localparam int PULSE_FULL_CNT = `PULSE_FULL_HZ / 1000 * (`PULSE_GATE_NS / 1000) / 1000;

	initial begin
		if (NUM_DI < 1 || NUM_DI > 5 || NUM_DO < 1 || NUM_DO > 2 || GATE_CYCLES < 1)
			$error("freq_ref_core: unsupported parameters");
		if (PULSE_FULL_CNT != `FULL_SCALE)
			$error("freq_ref_core: pulse gate must give full scale counts");
	end

	// ***********************************
	// software registers
	// ***********************************
	bus_state_t       state_r;
	logic [31:0]      src_ctrl_r;
	logic [11:0]      binding_r;
	logic [15:0]      maxf_r;
	logic [7:0]       curve_sel_r;
	logic [31:0]      pulse_line_r;
	logic [15:0]      updown_preset_r;
	logic [15:0]      updown_r;
	logic [15:0]      comm_r;
	logic [15:0]      len_set_r;
	logic [15:0]      ppm_r;
	logic [15:0]      cnt_set_r;
	logic [15:0]      cnt_desig_r;
	logic [29:0]      di_func_r;
	logic [11:0]      do_func_r;

	wire        bus_req    = read | write;
	wire        wr_fire    = write & (state_r == BUS_DONE);
	wire [31:0] be_mask    = {{8{byteenable[3]}}, {8{byteenable[2]}},
	                          {8{byteenable[1]}}, {8{byteenable[0]}}};
	wire        multi_hit  = address[7:6] == 2'b10;
	wire        curve_hit  = address[7:5] == 3'b110 && address[4:2] < 3'd5;
	wire        wr_multi   = wr_fire & multi_hit;
	wire        wr_curve   = wr_fire & curve_hit;

	assign waitrequest = bus_req & (state_r != BUS_DONE);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [31:0] m);
		return (old & ~m) | (nw & m);
	endfunction

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			state_r <= BUS_IDLE;
		else
			unique case (state_r)
				BUS_IDLE: state_r <= bus_req ? BUS_DONE : BUS_IDLE;
				BUS_DONE: state_r <= BUS_IDLE;
				default:  state_r <= BUS_IDLE;
			endcase
	end

	// ***********************************
	// terminal function decode
	// ***********************************
	logic [NUM_DI-1:0] di_prev_r;
	logic [NUM_DI-1:0] is_up, is_down, is_switch, is_count, is_len_rst, is_pid;
	logic [3:0]        multi_idx;

	for (genvar i = 0; i < NUM_DI; i++) begin : g_di
		wire [5:0] fn = di_func_r[6*i +: 6];
		wire       rise = di_in[i] & ~di_prev_r[i];
		assign is_up[i]      = fn == `DI_FN_UP && rise;
		assign is_down[i]    = fn == `DI_FN_DOWN && rise;
		assign is_switch[i]  = fn == `DI_FN_SWITCH && di_in[i];
		assign is_count[i]   = fn == `DI_FN_COUNT && rise;
		assign is_len_rst[i] = fn == `DI_FN_LEN_RST && di_in[i];
		assign is_pid[i]     = fn == `DI_FN_PID_SET && di_in[i];
	end

	// [RQ12] unassigned index bits zero
	for (genvar b = 0; b < 4; b++) begin : g_mi
		logic [NUM_DI-1:0] hit;
		for (genvar i = 0; i < NUM_DI; i++) begin : g_bit
			assign hit[i] = di_func_r[6*i +: 6] == `DI_FN_MULTI0 + 6'(b) && di_in[i];
		end
		assign multi_idx[b] = |hit;
	end

	wire fast_rise  = di_in[FAST] & ~di_prev_r[FAST];
	// [RQ18] length on the fast input only
	wire len_pulse  = fast_rise && di_func_r[6*FAST +: 6] == `DI_FN_LEN;
	wire cnt_pulse  = |is_count;
	wire freq_sw    = |is_switch;

	// ***********************************
	// table memories
	// ***********************************
	logic [15:0] multi_word;
	logic [31:0] curve_one, curve_two;

	// [RQ11] sixteen stored fractions
	param_mem #(.WIDTH(16), .DEPTH(16)) u_multi (
		.core_clk (core_clk),
		.wr_en    (wr_multi),
		.wr_addr  (address[5:2]),
		.wr_data  (writedata[15:0]),
		.rd_addr  (multi_idx),
		.rd_data  (multi_word)
	);

	// [RQ7] five curves, one copy per analog input
	param_mem #(.WIDTH(32), .DEPTH(5)) u_curve_one (
		.core_clk (core_clk),
		.wr_en    (wr_curve),
		.wr_addr  (address[4:2]),
		.wr_data  (writedata),
		.rd_addr  (curve_sel_r[2:0]),
		.rd_data  (curve_one)
	);

	param_mem #(.WIDTH(32), .DEPTH(5)) u_curve_two (
		.core_clk (core_clk),
		.wr_en    (wr_curve),
		.wr_addr  (address[4:2]),
		.wr_data  (writedata),
		.rd_addr  (curve_sel_r[`F_CURVE2_LSB +: 3]),
		.rd_data  (curve_two)
	);

	// ***********************************
	// pulse frequency measurement
	// ***********************************
	logic [31:0] gate_cnt_r;
	logic [15:0] pcnt_r;
	logic [10:0] pulse_pm_r;

	wire         gate_end = gate_cnt_r == 32'(GATE_CYCLES - 1);
	wire  [15:0] pcnt_nxt = pcnt_r + 16'(fast_rise);

	// [RQ8] edges per gate equal 0.1 % of 100 kHz
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gate_cnt_r <= '0;
			pcnt_r     <= '0;
			pulse_pm_r <= '0;
		end else begin
			gate_cnt_r <= gate_end ? '0 : gate_cnt_r + 32'd1;
			pcnt_r     <= gate_end ? '0 : pcnt_nxt;
			if (gate_end)
				pulse_pm_r <= pcnt_nxt > 16'(`FULL_SCALE) ? 11'(`FULL_SCALE) : pcnt_nxt[10:0];
		end
	end

	// ***********************************
	// channel values, 0.1 % of maximum
	// ***********************************
	// [RQ6] [RQ8] two-point line, 100 % maps to full scale
	function automatic setting_t map_line(input logic [10:0] x, input logic [31:0] p);
		int x0, y0, x1, y1, xi, r;
		x0 = int'(p[7:0]) * 10;
		y0 = int'(p[15:8]) * 10;
		x1 = int'(p[23:16]) * 10;
		y1 = int'(p[31:24]) * 10;
		xi = int'(x);
		if (xi <= x0)
			r = y0;
		else if (xi >= x1)
			r = y1;
		else
			r = y0 + (xi - x0) * (y1 - y0) / (x1 - x0);
		return setting_t'(r);
	endfunction

	wire setting_t ain_one  = map_line({1'b0, analog_input_one}, curve_one);
	wire setting_t ain_two  = map_line({1'b0, analog_input_two}, curve_two);
	wire setting_t pulse_v  = map_line(pulse_pm_r, pulse_line_r);

	// [RQ2] one channel per selector code
	function automatic setting_t src_val(input logic [3:0] code, input setting_t a1,
			input setting_t a2, input setting_t pv);
		unique case (code)
			SRC_UPDOWN, SRC_UPDOWN_RET: return setting_t'(updown_r);
			SRC_AIN_ONE: return a1;
			SRC_AIN_TWO: return a2;
			SRC_PULSE:   return pv;
			SRC_MULTI:   return setting_t'(multi_word);
			SRC_PROGRAM: return setting_t'(program_setting);
			SRC_PID:     return setting_t'(pid_setting);
			SRC_COMM:    return setting_t'($signed(comm_r));
			default:     return '0;
		endcase
	endfunction

	// [RQ1] independent main and aux channels
	// an assign would miss registers read inside src_val
	setting_t      main_v, aux_v;
	always_comb begin
		main_v = src_val(src_ctrl_r[`F_MAIN_LSB +: 4], ain_one, ain_two, pulse_v);
		aux_v  = src_val(src_ctrl_r[`F_AUX_LSB +: 4], ain_one, ain_two, pulse_v);
	end

	// [RQ4] arithmetic combination
	wire [1:0]     op     = src_ctrl_r[`F_OP_LSB +: 2];
	wire setting_t arith_v = op == OP_ADD ? main_v + aux_v :
	                         op == OP_SUB ? main_v - aux_v :
	                         op == OP_MAX ? (main_v > aux_v ? main_v : aux_v) :
	                                        (main_v < aux_v ? main_v : aux_v);

	// [RQ3] combination and switchover
	wire [2:0]     comb    = src_ctrl_r[`F_COMB_LSB +: 3];
	wire setting_t comb_v  = comb == CMB_MAIN  ? main_v :
	                         comb == CMB_AUX   ? aux_v :
	                         comb == CMB_ARITH ? arith_v :
	                         comb == CMB_SW_MA ? (freq_sw ? aux_v : main_v) :
	                         comb == CMB_SW_MR ? (freq_sw ? arith_v : main_v) :
	                         comb == CMB_SW_AR ? (freq_sw ? arith_v : aux_v) : main_v;

	// [RQ5] bound command source overrides both channels
	wire [1:0]     cmd_src = src_ctrl_r[`F_CMD_LSB +: 2];
	wire [3:0]     bind_d  = cmd_src == 2'd3 ? 4'h0 : binding_r[4*cmd_src +: 4];
	setting_t      bind_v;
	always_comb bind_v = src_val(bind_d - 4'h1, ain_one, ain_two, pulse_v);
	wire setting_t final_v = bind_d != 4'h0 ? bind_v : comb_v;

	// ***********************************
	// direction and output frequency
	// ***********************************
	wire           negative = final_v < 0;
	wire setting_t abs_v    = negative ? -final_v : final_v;
	wire [10:0]    mag      = abs_v > setting_t'(`FULL_SCALE) ? 11'(`FULL_SCALE) : abs_v[10:0];
	// [RQ12] fraction times maximum frequency
	wire [26:0]    prod     = 27'(mag) * 27'(maxf_r);
	wire [15:0]    freq_v   = 16'(prod / 27'(`FULL_SCALE));
	// [RQ14] negative set value asks for reverse
	wire           rev_req  = rev_cmd | negative;
	// [RQ15] inhibit blocks any reverse request
	wire           blocked  = src_ctrl_r[`F_REV_INHIBIT] & rev_req;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			target_freq  <= '0;
			run_reverse  <= 1'b0;
			drive_enable <= 1'b0;
			pid_set_sel  <= 1'b0;
		end else begin
			target_freq  <= blocked ? 16'h0000 : freq_v;
			// [RQ13] invert flips the commanded direction
			run_reverse  <= ~blocked & (rev_req ^ src_ctrl_r[`F_INVERT]);
			drive_enable <= run_cmd & ~blocked;
			// [RQ10] controller set, automatic or by input
			pid_set_sel  <= src_ctrl_r[`F_PID_AUTO] ? pid_dev_large : |is_pid;
		end
	end

	// ***********************************
	// up/down setting
	// ***********************************
	logic run_prev_r;
	wire  up_ev    = |is_up;
	wire  down_ev  = |is_down;
	// non-retentive mode falls back to its preset on stop
	wire  ud_drop  = run_prev_r & ~run_cmd &
	                 (src_ctrl_r[`F_MAIN_LSB +: 4] == SRC_UPDOWN ||
	                  src_ctrl_r[`F_AUX_LSB +: 4] == SRC_UPDOWN);
	wire [15:0] ud_step = up_ev && !down_ev && updown_r < 16'(`FULL_SCALE) ? updown_r + 16'h1 :
	                      down_ev && !up_ev && updown_r != 16'h0 ? updown_r - 16'h1 : updown_r;

	// ***********************************
	// length and event counters
	// ***********************************
	logic [31:0] plen_r;
	logic [15:0] act_len_r;
	logic [15:0] cnt_r;
	logic        len_hit_r, cnt_set_hit_r, cnt_des_hit_r;

	wire         cnt_wr    = wr_fire && address == `OFS_CNT_VALUE;
	// [RQ17] reset input clears length
	wire [31:0]  plen_nxt  = |is_len_rst ? 32'h0 : plen_r + 32'(len_pulse);
	// [RQ16] pulses over pulses per meter
	wire [15:0]  act_nxt   = ppm_r == 16'h0 ? 16'h0 : 16'(plen_nxt / 32'(ppm_r));
	// [RQ19] stop once set count reached
	wire         cnt_run   = cnt_pulse && cnt_r < cnt_set_r;
	wire [15:0]  cnt_nxt   = cnt_wr ? 16'(merge(32'(cnt_r), writedata, be_mask)) :
	                         cnt_r + 16'(cnt_run);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			di_prev_r     <= '0;
			run_prev_r    <= 1'b0;
			plen_r        <= '0;
			act_len_r     <= '0;
			cnt_r         <= '0;
			len_hit_r     <= 1'b0;
			cnt_set_hit_r <= 1'b0;
			cnt_des_hit_r <= 1'b0;
		end else begin
			di_prev_r     <= di_in;
			run_prev_r    <= run_cmd;
			plen_r        <= plen_nxt;
			act_len_r     <= act_nxt;
			cnt_r         <= cnt_nxt;
			// [RQ23] flags update in the same cycle as the counter
			len_hit_r     <= act_nxt > len_set_r;
			cnt_set_hit_r <= cnt_nxt >= cnt_set_r;
			// [RQ20] designated point, counting goes on
			cnt_des_hit_r <= cnt_nxt >= cnt_desig_r;
		end
	end

	for (genvar k = 0; k < NUM_DO; k++) begin : g_do
		wire [5:0] fn = do_func_r[6*k +: 6];
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n)
				do_out[k] <= 1'b0;
			else
				do_out[k] <= (fn == `DO_FN_CNT_SET && cnt_set_hit_r) ||
				             (fn == `DO_FN_CNT_DES && cnt_des_hit_r) ||
				             (fn == `DO_FN_LEN && len_hit_r);
		end
	end

	// ***********************************
	// register writes
	// ***********************************
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			src_ctrl_r      <= `SRC_CTRL_RST;
			binding_r       <= '0;
			maxf_r          <= `MAX_FREQ_RST;
			curve_sel_r     <= '0;
			pulse_line_r    <= `PULSE_LINE_RST;
			updown_preset_r <= '0;
			updown_r        <= '0;
			comm_r          <= '0;
			len_set_r       <= '0;
			ppm_r           <= `PPM_RST;
			cnt_set_r       <= '0;
			cnt_desig_r     <= '0;
			di_func_r       <= '0;
			do_func_r       <= `DO_FUNC_RST;
		end else begin
			updown_r <= ud_drop ? updown_preset_r : ud_step;
			if (wr_fire)
				unique case (address)
					`OFS_SRC_CTRL:   src_ctrl_r   <= merge(src_ctrl_r, writedata, be_mask);
					`OFS_BINDING:    binding_r    <= 12'(merge(32'(binding_r), writedata, be_mask));
					`OFS_MAX_FREQ:   maxf_r       <= 16'(merge(32'(maxf_r), writedata, be_mask));
					`OFS_CURVE_SEL:  curve_sel_r  <= 8'(merge(32'(curve_sel_r), writedata, be_mask));
					`OFS_PULSE_LINE: pulse_line_r <= merge(pulse_line_r, writedata, be_mask);
					`OFS_UPDOWN: begin
						updown_preset_r <= 16'(merge(32'(updown_r), writedata, be_mask));
						updown_r        <= 16'(merge(32'(updown_r), writedata, be_mask));
					end
					`OFS_COMM_FREQ:  comm_r       <= 16'(merge(32'(comm_r), writedata, be_mask));
					`OFS_LEN_SET:    len_set_r    <= 16'(merge(32'(len_set_r), writedata, be_mask));
					`OFS_PULSE_PM:   ppm_r        <= 16'(merge(32'(ppm_r), writedata, be_mask));
					`OFS_CNT_SET:    cnt_set_r    <= 16'(merge(32'(cnt_set_r), writedata, be_mask));
					`OFS_CNT_DESIG:  cnt_desig_r  <= 16'(merge(32'(cnt_desig_r), writedata, be_mask));
					`OFS_DI_FUNC:    di_func_r    <= 30'(merge(32'(di_func_r), writedata, be_mask));
					`OFS_DO_FUNC:    do_func_r    <= 12'(merge(32'(do_func_r), writedata, be_mask));
					default: ;
				endcase
		end
	end

	// ***********************************
	// read data
	// ***********************************
	wire [31:0] status_w = {11'h0, pid_set_sel, drive_enable, cnt_des_hit_r, cnt_set_hit_r,
	                        len_hit_r, target_freq};
	wire [31:0] rd_mux   = address == `OFS_SRC_CTRL   ? src_ctrl_r :
	                       address == `OFS_BINDING    ? 32'(binding_r) :
	                       address == `OFS_MAX_FREQ   ? 32'(maxf_r) :
	                       address == `OFS_CURVE_SEL  ? 32'(curve_sel_r) :
	                       address == `OFS_PULSE_LINE ? pulse_line_r :
	                       address == `OFS_UPDOWN     ? 32'(updown_r) :
	                       address == `OFS_COMM_FREQ  ? 32'(comm_r) :
	                       address == `OFS_LEN_SET    ? 32'(len_set_r) :
	                       address == `OFS_PULSE_PM   ? 32'(ppm_r) :
	                       address == `OFS_ACT_LEN    ? 32'(act_len_r) :
	                       address == `OFS_CNT_SET    ? 32'(cnt_set_r) :
	                       address == `OFS_CNT_DESIG  ? 32'(cnt_desig_r) :
	                       // [RQ22] count readable and restorable
	                       address == `OFS_CNT_VALUE  ? 32'(cnt_r) :
	                       address == `OFS_STATUS     ? status_w :
	                       address == `OFS_DI_FUNC    ? 32'(di_func_r) :
	                       address == `OFS_DO_FUNC    ? 32'(do_func_r) : 32'h0000_0000;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			readdata <= '0;
		else if (state_r == BUS_IDLE && read)
			readdata <= rd_mux;
	end
endmodule // freq_ref_core

// ==== verification/terminal_model.sv ====
module terminal_model (
	// clock
	input  wire logic       core_clk,
	// requested levels and one-shot pulses
	input  wire logic [4:0] lvl,
	input  wire logic [4:0] pls,
	// terminal levels
	output logic      [4:0] di
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] p_r;
	// pulses only, one cycle high
	// low gap forced so every pulse is a fresh rise
	always_ff @(posedge core_clk) p_r <= pls & ~p_r;
	assign di = lvl | p_r;
endmodule // terminal_model

// ==== verification/freq_ref_core_monitor.sv ====
module freq_ref_core_monitor #(parameter int NUM_DO = 2) (
	// bus
	input wire logic              core_clk,
	input wire logic              arst_n,
	input wire logic              read,
	input wire logic              write,
	input wire logic              waitrequest,
	input wire logic [31:0]       readdata,
	// drive side
	input wire logic              run_cmd,
	input wire logic              drive_enable,
	input wire logic [15:0]       target_freq,
	input wire logic [NUM_DO-1:0] do_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	property p_wait_one; (read | write) && waitrequest |=> !waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait too long");
	property p_idle; !(read | write) |-> !waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("wait without request");
	property p_rd_wait; read && !waitrequest |-> $past(waitrequest); endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read answered early");
	property p_rd_hold; !read ##1 !read |-> $stable(readdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_run; !$past(run_cmd) |-> !drive_enable; endproperty
	a_run: assert property (p_run) else $error("enable without run");
	property p_block; $past(run_cmd) && !drive_enable |-> target_freq == 16'h0; endproperty
	a_block: assert property (p_block) else $error("blocked but frequency");
	// a bus write may retarget the counter, so skip that window
	property p_set_hold;
		do_out[0] && !write && !$past(write) && !$past(write, 2) |=> do_out[0];
	endproperty
	a_set_hold: assert property (p_set_hold) else $error("set reach dropped");
	property p_des_first; $rose(do_out[0]) |-> do_out[1]; endproperty
	a_des_first: assert property (p_des_first) else $error("set before designated");
	cover property (read && !waitrequest);
	cover property ($rose(do_out[1]));
	cover property ($rose(do_out[0]));
endmodule // freq_ref_core_monitor
bind freq_ref_core freq_ref_core_monitor #(.NUM_DO(NUM_DO)) u_mon (.core_clk, .arst_n,
	.read, .write, .waitrequest, .readdata, .run_cmd, .drive_enable, .target_freq, .do_out);

// ==== verification/drive_frequency_reference_and_counters_tb_top.sv ====
`include "freq_ref_cfg.svh"
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin error_cnt++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, x, y); end end
module drive_frequency_reference_and_counters_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, arst_n = 0, read = 0, write = 0, run_cmd = 0, rev_cmd = 0, pdl = 0;
	logic [7:0] address = '0;
	logic [31:0] writedata = '0, readdata, e, m, qe[$], qm[$];
	logic [9:0] ain1 = '0, ain2 = '0;
	logic [4:0] lvl = '0, pls = '0, di_in;
	logic waitrequest, run_reverse, drive_enable, pid_set_sel;
	logic [15:0] target_freq, pid = '0;
	logic [1:0] do_out;
	int error_cnt = 0, checks_done = 0, a, b, v;
	freq_ref_core #(.NUM_DI(5), .NUM_DO(2)) DUT (.core_clk, .arst_n, .address, .read,
		.write, .writedata, .byteenable(4'hf), .readdata, .waitrequest, .di_in,
		.analog_input_one(ain1), .analog_input_two(ain2), .run_cmd, .rev_cmd,
		.pid_setting(pid), .program_setting(16'sh0), .pid_dev_large(pdl),
		.target_freq, .run_reverse, .drive_enable, .pid_set_sel, .do_out);
	terminal_model TM (.core_clk, .lvl, .pls, .di(di_in));
	initial forever #5 core_clk = ~core_clk;
	task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		address <= ad; read <= !w; write <= w; writedata <= d;
		do @(posedge core_clk); while (waitrequest);
		read <= 1'b0; write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d); bus(ad, 1'b1, d); endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] mk);
		qe.push_back(ex); qm.push_back(mk); bus(ad, 1'b0, 32'h0);
	endtask
	task automatic st; repeat (4) @(posedge core_clk); @(negedge core_clk); endtask
	task automatic pulse(input logic [4:0] p, input int n);
		repeat (n) begin
			@(posedge core_clk) pls <= p;
			@(posedge core_clk) pls <= 5'h0;
			@(posedge core_clk);
		end
		st;
	endtask
	task automatic conclude;
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one note per read, taken off when the answer stands
	always @(posedge core_clk) if (read && !waitrequest) begin
		e = qe.pop_front(); m = qm.pop_front(); `CHK(readdata & m, e)
	end
	initial begin
		void'($urandom(32'h80a7));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(`OFS_MAX_FREQ, 32'h1388, 32'hffff);
		rd(`OFS_PULSE_LINE, 32'h6464_0000, 32'hffff_ffff);
		rd(8'h44, 32'h0, 32'hffff_ffff);
		rd(`OFS_DO_FUNC, 32'h248, 32'hfff);
		wr(`OFS_CURVE_BASE, 32'h6464_0000);
		run_cmd <= 1'b1;
		// main, aux, then sum, difference, larger, smaller; a > b keeps it positive
		for (int c = 0; c < 6; c++) begin
			a = 300 + $urandom_range(199); b = $urandom_range(299);
			ain1 <= a[9:0]; ain2 <= b[9:0];
			wr(`OFS_SRC_CTRL, 32'(32'h32 | ((c > 1 ? 2 : c) << 8) | ((c > 1 ? c - 2 : 0) << 12)));
			v = c == 0 ? a : c == 1 ? b : c == 2 ? a + b : c == 3 ? a - b : c == 4 ? a : b;
			st; rd(`OFS_STATUS, 32'(32'h8_0000 | (v * 5)), 32'h18_ffff);
		end
		wr(`OFS_COMM_FREQ, 32'd400);
		wr(`OFS_BINDING, 32'ha); st; rd(`OFS_STATUS, 32'h8_07d0, 32'h18_ffff);
		wr(`OFS_BINDING, 32'h0); wr(`OFS_SRC_CTRL, 32'h9); st;
		rd(`OFS_STATUS, 32'h8_07d0, 32'h18_ffff);
		wr(`OFS_COMM_FREQ, 32'hffff_ff38); st; `CHK(run_reverse, 1'b1)
		rd(`OFS_STATUS, 32'h8_03e8, 32'h18_ffff);
		wr(`OFS_SRC_CTRL, 32'h2_0009); st; rd(`OFS_STATUS, 32'h0, 32'h8_ffff);
		wr(`OFS_COMM_FREQ, 32'd400); rev_cmd <= 1'b1; st;
		rd(`OFS_STATUS, 32'h0, 32'h8_ffff);
		rev_cmd <= 1'b0; wr(`OFS_SRC_CTRL, 32'h1_0009); st; `CHK(run_reverse, 1'b1)
		v = $urandom_range(1000); wr(`OFS_SRC_CTRL, 32'h4_0008);
		pid <= 16'(v); pdl <= 1'b1; st;
		rd(`OFS_STATUS, 32'(32'h18_0000 | (v * 5)), 32'h18_ffff);
		// one multi bit on terminal 1 only, the other bits unassigned
		v = $urandom_range(1000);
		wr(`OFS_DI_FUNC, 32'h1b01_c359); wr(`OFS_MULTI_BASE + 8'h8, 32'(v));
		wr(`OFS_SRC_CTRL, 32'h6); lvl <= 5'h2; st;
		rd(`OFS_STATUS, 32'(32'h8_0000 | (v * 5)), 32'h18_ffff);
		lvl <= 5'h0;
		wr(`OFS_CNT_SET, 32'd3); wr(`OFS_CNT_DESIG, 32'd2); wr(`OFS_CNT_VALUE, 32'd0);
		pulse(5'h1, 2); `CHK(do_out, 2'b10)
		pulse(5'h1, 2); `CHK(do_out, 2'b11)
		rd(`OFS_CNT_VALUE, 32'd3, 32'hffff);
		wr(`OFS_LEN_SET, 32'd2); pulse(5'h10, 3);
		rd(`OFS_ACT_LEN, 32'd3, 32'hffff);
		rd(`OFS_STATUS, 32'h1_0000, 32'h1_0000);
		pulse(5'h4, 1); rd(`OFS_ACT_LEN, 32'd0, 32'hffff);
		st; conclude;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		conclude;
	end
endmodule // drive_frequency_reference_and_counters_tb_top
